/* sweep_irq_map.vh */
// Purpose: Constants for sweep interrupt, readback and fast-lock control
// Assumes: Single clock domain, 20 MHz ref_clk
// Notes: Field codes as held in the device's configuration registers
`ifndef SWEEP_IRQ_MAP_VH
`define SWEEP_IRQ_MAP_VH

`define IRQ_MODE_OFF 2'h0
`define IRQ_MODE_CONTINUE 2'h1
`define IRQ_MODE_HALT 2'h3
`define CLKDIV_MODE_FASTLOCK 2'h1
`define CLKDIV_SEL_READBACK 2'h2
`define MULTIPLEXED_OUTPUT_PIN_SEL_READBACK 4'hf
`define INT_WIDTH 12
`define FRAC_WIDTH 25
`define READBACK_BITS 37
`define TIMER_WIDTH 12
`define AUXDIV_WIDTH 12
`define CP_BOOST_SHIFT 4
`define CP_WIDTH 4

`endif

/* readback_shifter.v */
// Purpose: Holds the 37-bit captured divider word and shifts it out serially
// Assumes: Serial clock is a plain input sampled on ref_clk
// Notes: Bit launched on serial clock rise, host samples on fall
`timescale 1ns/1ps
`default_nettype none
`include "sweep_irq_map.vh"

module readback_shifter #(
    parameter WORD_BITS = `READBACK_BITS
) (
    input wire ref_clk, // System clock
    input wire nrst, // Async reset, active low
    input wire capture, // Load word pulse
    input wire [WORD_BITS-1:0] word_in, // Word to capture
    input wire sclk_rise, // Serial clock rising edge pulse
    output reg sdo_q, // Serial data bit
    output reg busy_q // Word loaded, not yet fully shifted
);

reg [WORD_BITS-1:0] shreg_q;
reg [5:0] left_q;

////////////////////////////////////////////////////////////////////////
always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        shreg_q <= {WORD_BITS{1'b0}};
        left_q <= 6'h00;
        sdo_q <= 1'b0;
        busy_q <= 1'b0;
    end else if (capture && !busy_q) begin
        // Word frozen until fully shifted; later captures ignored
        shreg_q <= word_in;
        left_q <= WORD_BITS[5:0];
        busy_q <= 1'b1;
    end else if (busy_q && sclk_rise) begin
        sdo_q <= shreg_q[WORD_BITS-1];
        shreg_q <= {shreg_q[WORD_BITS-2:0], 1'b0};
        left_q <= left_q - 6'h01;
        if (left_q == 6'h01) begin
            busy_q <= 1'b0;
        end
    end
end

endmodule
`default_nettype wire

/* sweep_irq_fastlock.v */
// Purpose: Sweep interrupt with divider readback, and fast-lock timer
// Assumes: All inputs synchronous to ref_clk; one clock domain
// Notes: Serial clock edges detected on ref_clk, so it must run slower
`timescale 1ns/1ps
`default_nettype none
`include "sweep_irq_map.vh"

// Function
// - A sweep interrupt fires on a rising edge of the modulation trigger, never on a falling one.
// - Interrupt mode 00 is off, 01 interrupts with the sweep running, 11 interrupts and halts the sweep.
// - On interrupt, unless the previous word is still shifting out, the integer and fractional divide values are captured for readback on the output pin.
// - The readback word is 37 bits: 12 integer bits above 25 fractional bits.
// - Each readback bit is launched on a serial clock rise and sampled by the host on the next fall.
// - With divider mode 01 the fast-lock timer value comes from the 12-bit clock divider value.
// - Wide bandwidth lasts auxiliary divide word (zero taken as one) times timer value comparison periods.
// - Fast lock does not run while a frequency ramp is being generated.
// - In wide bandwidth the charge pump current setting is multiplied by 16.
// - During fast lock the first switch goes to ground, the second to the pump output, both released after.
module sweep_irq_fastlock #(
    parameter TIMER_W = `TIMER_WIDTH,
    parameter AUX_W = `AUXDIV_WIDTH
) (
    input wire ref_clk, // 20 MHz clock
    input wire nrst, // Async reset, active low
    input wire modulation_trigger_input, // Trigger input
    input wire [1:0] irq_mode, // Interrupt mode field
    input wire [`INT_WIDTH-1:0] int_value, // Live integer divide value
    input wire [`FRAC_WIDTH-1:0] frac_value, // Live fractional divide value
    input wire [1:0] clkdiv_sel, // Clock divider select field
    input wire [3:0] multiplexed_output_pin_sel, // Output mux control field
    input wire sclk, // Serial interface clock
    input wire pfd_tick, // One pulse per comparison period
    input wire [1:0] clkdiv_mode, // Clock divider mode field
    input wire [TIMER_W-1:0] clkdiv_value, // 12-bit clock divider value
    input wire [AUX_W-1:0] auxiliary_divide_word, // Auxiliary divide word
    input wire fastlock_start, // Pulse: new frequency loaded
    input wire ramp_active, // Ramp generation running
    input wire [`CP_WIDTH-1:0] cp_setting, // Programmed pump current
    output wire multiplexed_output_pin, // Readback data out
    output reg irq_q, // Interrupt pulse
    output reg sweep_halt_q, // Sweep stopped by interrupt
    output reg readback_ready_q, // Readback word pending
    output reg wide_band_q, // Wide bandwidth active
    output reg [`CP_WIDTH+`CP_BOOST_SHIFT-1:0] cp_current_q, // Effective pump current
    output reg first_loop_switch_pin, // High: tied to ground
    output reg second_loop_switch_pin // High: tied to pump output
);

reg trig_prev_q;
reg sclk_prev_q;
reg capture_q;
reg [`READBACK_BITS-1:0] word_q;
reg [TIMER_W+AUX_W-1:0] fl_count_q;
wire trig_rise;
wire sclk_rise;
wire irq_enabled;
wire rb_busy;
wire rb_bit;
wire rb_selected;

////////////////////////////////////////////////////////////////////////
// Interrupt detect
assign trig_rise = modulation_trigger_input && !trig_prev_q;
assign irq_enabled = (irq_mode == `IRQ_MODE_CONTINUE) || (irq_mode == `IRQ_MODE_HALT);
assign sclk_rise = sclk && !sclk_prev_q;

always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        trig_prev_q <= 1'b0;
        sclk_prev_q <= 1'b0;
        irq_q <= 1'b0;
        sweep_halt_q <= 1'b0;
        capture_q <= 1'b0;
        word_q <= {`READBACK_BITS{1'b0}};
    end else begin
        trig_prev_q <= modulation_trigger_input;
        sclk_prev_q <= sclk;
        irq_q <= trig_rise && irq_enabled;
        capture_q <= trig_rise && irq_enabled;
        if (trig_rise && irq_enabled) begin
            word_q <= {int_value, frac_value};
        end
        // Halt holds until mode no longer asks for it
        if (trig_rise && irq_mode == `IRQ_MODE_HALT) begin
            sweep_halt_q <= 1'b1;
        end else if (irq_mode != `IRQ_MODE_HALT) begin
            sweep_halt_q <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Readback
readback_shifter #(
    .WORD_BITS(`READBACK_BITS)
) u_shift (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .capture(capture_q),
    .word_in(word_q),
    .sclk_rise(sclk_rise),
    .sdo_q(rb_bit),
    .busy_q(rb_busy)
);

assign rb_selected = (clkdiv_sel == `CLKDIV_SEL_READBACK) && (multiplexed_output_pin_sel == `MULTIPLEXED_OUTPUT_PIN_SEL_READBACK);
assign multiplexed_output_pin = rb_selected ? rb_bit : 1'b0;

always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        readback_ready_q <= 1'b0;
    end else begin
        readback_ready_q <= rb_busy;
    end
end

////////////////////////////////////////////////////////////////////////
// Fast-lock timer
// Product computed once at start, so mid-period writes do not stretch it
always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        fl_count_q <= {(TIMER_W+AUX_W){1'b0}};
        wide_band_q <= 1'b0;
    end else if (ramp_active || clkdiv_mode != `CLKDIV_MODE_FASTLOCK) begin
        fl_count_q <= {(TIMER_W+AUX_W){1'b0}};
        wide_band_q <= 1'b0;
    end else if (fastlock_start) begin
        // Zero auxiliary word treated as one
        if (auxiliary_divide_word == {AUX_W{1'b0}}) begin
            fl_count_q <= {{AUX_W{1'b0}}, clkdiv_value};
        end else begin
            fl_count_q <= clkdiv_value * auxiliary_divide_word;
        end
        wide_band_q <= (clkdiv_value != {TIMER_W{1'b0}});
    end else if (wide_band_q && pfd_tick) begin
        fl_count_q <= fl_count_q - {{(TIMER_W+AUX_W-1){1'b0}}, 1'b1};
        if (fl_count_q == {{(TIMER_W+AUX_W-1){1'b0}}, 1'b1}) begin
            wide_band_q <= 1'b0;
        end
    end
end

always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        cp_current_q <= {(`CP_WIDTH+`CP_BOOST_SHIFT){1'b0}};
        first_loop_switch_pin <= 1'b0;
        second_loop_switch_pin <= 1'b0;
    end else begin
        if (wide_band_q) begin
            cp_current_q <= {cp_setting, {`CP_BOOST_SHIFT{1'b0}}};
        end else begin
            cp_current_q <= {{`CP_BOOST_SHIFT{1'b0}}, cp_setting};
        end
        first_loop_switch_pin <= wide_band_q;
        second_loop_switch_pin <= wide_band_q;
    end
end

endmodule
`default_nettype wire

/* sweep_props_properties.sv */
// Purpose: Port properties of the sweep interrupt and fast-lock block
// Assumes: Bound to sweep_irq_fastlock, one clock
// Notes: Outputs are judged one edge after their cause
`timescale 1ns/1ps
`default_nettype none
module sweep_props (
    input wire logic ref_clk, // Clock
    input wire logic nrst, // Reset
    input wire logic modulation_trigger_input, // Trigger
    input wire logic [1:0] irq_mode, // Mode
    input wire logic irq_q, // Irq
    input wire logic sweep_halt_q, // Halt
    input wire logic ramp_active, // Ramp
    input wire logic [1:0] clkdiv_mode, // Div mode
    input wire logic wide_band_q, // Wide
    input wire logic [3:0] cp_setting, // Pump in
    input wire logic [7:0] cp_current_q, // Pump out
    input wire logic first_loop_switch_pin, // Switch 1
    input wire logic second_loop_switch_pin // Switch 2
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////
    a_irq_cause: assert property (irq_q |-> $past(modulation_trigger_input)
        && !$past(modulation_trigger_input, 2) && $past(irq_mode[0])) else $error("Irq without rise");
    a_irq_off: assert property ($rose(modulation_trigger_input) && !irq_mode[0] |=> !irq_q)
        else $error("Irq while off");
    a_irq_pulse: assert property (irq_q |=> !irq_q)
        else $error("Irq too long");
    a_halt_set: assert property ($rose(sweep_halt_q) |-> irq_q && $past(irq_mode) == 2'h3)
        else $error("Halt without halt irq");
    a_halt_hold: assert property (sweep_halt_q && irq_mode == 2'h3 |=> sweep_halt_q)
        else $error("Halt dropped");
    a_pump_boost: assert property ($past(nrst) |-> cp_current_q ==
        ($past(wide_band_q) ? {$past(cp_setting), 4'h0} : {4'h0, $past(cp_setting)})) else $error("Pump wrong");
    a_switch_follow: assert property ($past(nrst) |-> first_loop_switch_pin == $past(wide_band_q)
        && second_loop_switch_pin == $past(wide_band_q)) else $error("Switch wrong");
    a_ramp_block: assert property (ramp_active || clkdiv_mode != 2'h1 |=> !wide_band_q)
        else $error("Wide band not allowed");
endmodule
`default_nettype wire

/* serial_host.sv */
// Purpose: Host model reading the captured word over the serial clock
// Assumes: Serial clock slow enough for edge detection on ref_clk
// Notes: Clock idles low between frames
`timescale 1ns/1ps
`default_nettype none
module serial_host (
    input wire logic ref_clk, // Clock
    input wire logic go, // Start frame
    input wire logic pin, // Readback bit
    output logic sclk, // Serial clock
    output logic [36:0] word // Bits read
);
    initial sclk = 1'b0;
    always @(posedge go) begin : frame
        integer i;
        for (i = 0; i < 37; i = i + 1) begin
            repeat (3) @(negedge ref_clk);
            sclk = 1'b1;
            repeat (3) @(negedge ref_clk);
            sclk = 1'b0;
            word = {word[35:0], pin};
        end
    end
endmodule
`default_nettype wire

/* tb.sv */
// Purpose: Self-checking bench for sweep interrupt, readback and fast lock
// Assumes: Inputs driven on falling edges
// Notes: Readback wait fixed by the host model frame length
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic ref_clk, nrst, trig, sclk, pfd_tick, fastlock_start, ramp_active, go;
    logic [1:0] irq_mode, clkdiv_mode;
    logic [3:0] cp_setting;
    logic [11:0] int_value, clkdiv_value, aux;
    logic [24:0] frac_value;
    logic [36:0] word;
    wire pin, irq_q, halt, ready, wide, gnd_sw, pump_sw;
    wire [7:0] cp_current_q;
    integer fails = 0, n_checks = 0, n_irq = 0, n_tick = 0, ph = 0;
    sweep_irq_fastlock u_sweep_irq_fastlock (.ref_clk(ref_clk), .nrst(nrst), .modulation_trigger_input(trig),
        .irq_mode(irq_mode), .int_value(int_value), .frac_value(frac_value), .clkdiv_sel(2'h2),
        .multiplexed_output_pin_sel(4'hf), .sclk(sclk), .pfd_tick(pfd_tick), .clkdiv_mode(clkdiv_mode),
        .clkdiv_value(clkdiv_value), .auxiliary_divide_word(aux), .fastlock_start(fastlock_start),
        .ramp_active(ramp_active), .cp_setting(cp_setting), .multiplexed_output_pin(pin), .irq_q(irq_q),
        .sweep_halt_q(halt), .readback_ready_q(ready), .wide_band_q(wide), .cp_current_q(cp_current_q),
        .first_loop_switch_pin(gnd_sw), .second_loop_switch_pin(pump_sw));
    serial_host u_serial_host (.ref_clk(ref_clk), .go(go), .pin(pin), .sclk(sclk), .word(word));
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    always @(negedge ref_clk) begin
        ph <= (ph + 1) % 4;
        pfd_tick <= (ph == 3);
    end
    always @(posedge ref_clk) begin
        if (irq_q === 1'b1) n_irq <= n_irq + 1;
        if (wide === 1'b1 && pfd_tick === 1'b1) n_tick <= n_tick + 1;
    end
    task chk(input string nm, input logic [36:0] seen, input logic [36:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task trig_pulse(input logic [1:0] m);
        irq_mode = m;
        n_irq = 0;
        repeat (1) @(negedge ref_clk);
        trig = 1'b1;
        repeat (3) @(negedge ref_clk);
        trig = 1'b0;
        repeat (3) @(negedge ref_clk);
    endtask
    task read_back;
        go = 1'b1;
        @(negedge ref_clk);
        go = 1'b0;
        repeat (230) @(negedge ref_clk);
    endtask
    task results;
        if (fails == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #100000;
        fails = fails + 1;
        results;
    end
    initial begin
        {nrst, trig, go, fastlock_start, ramp_active, pfd_tick, irq_mode, clkdiv_mode} = 0;
        {clkdiv_value, aux, cp_setting, int_value, frac_value} = {24'h0, 4'h5, 12'h0e7, 25'h1623a78};
        repeat (2) @(negedge ref_clk);
        nrst = 1'b1;
        trig_pulse(2'h0);
        chk("irq off", n_irq, 0);
        trig_pulse(2'h2);
        chk("irq mode 10", n_irq, 0);
        trig_pulse(2'h1);
        chk("irq count", n_irq, 1);
        chk("halt cont", halt, 0);
        chk("ready", ready, 1);
        {int_value, frac_value} = {12'h123, 25'h0};
        read_back;
        chk("word", word, 37'h01cf623a78);
        chk("ready done", ready, 0);
        trig_pulse(2'h3);
        chk("halt", halt, 1);
        read_back;
        chk("word 2", word, {12'h123, 25'h0});
        {clkdiv_mode, clkdiv_value, aux, fastlock_start} = {2'h1, 12'h003, 12'h005, 1'b1};
        @(negedge ref_clk);
        fastlock_start = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk("wide", wide, 1);
        chk("pump boost", cp_current_q, 8'h50);
        chk("switches", {gnd_sw, pump_sw}, 2'h3);
        repeat (80) @(negedge ref_clk);
        chk("ticks", n_tick, 15);
        chk("switches off", {gnd_sw, pump_sw}, 2'h0);
        chk("pump", cp_current_q, 8'h05);
        {ramp_active, fastlock_start} = 2'h3;
        @(negedge ref_clk);
        fastlock_start = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk("wide ramp", wide, 0);
        results;
    end
endmodule
bind sweep_irq_fastlock sweep_props u_sweep_props (.*);
`default_nettype wire
